// file: hw/sol_regs.sv
/*
 * system option and low-voltage register bank: watchdog clock and window
 * control with service-window checking, converter trigger selection,
 * divided clock output, part identification, low-voltage warning and
 * detect control, sticky interrupt status with mask.
 * assumes a single-cycle register port with read data one cycle later,
 * and analog/status inputs already synchronous to i_clock.
 */
//
// Contract
// RULE1 - watchdog clock select is write-once; 0 picks 1 kHz clock, 1 bus clock.
// RULE2 - in window mode the 0x55, 0xaa service belongs in the last quarter.
// RULE3 - in window mode an early reset-status write resets.
// RULE4 - write-once bits take only the first write after reset.
// RULE5 - trigger select picks counter overflow (0) or interrupt pin (1).
// RULE6 - nonzero divide field drives clock out at bus rate over twice field.
// RULE7 - all-zero divide field disables the divided clock output.
// RULE8 - id registers are read-only with a fixed part number.
// RULE9 - high identification register holds a fixed silicon revision.
// RULE10 - warning flag sets below the warning point, holds until acknowledged.
// RULE11 - acknowledge clears the warning flag only once the warning is gone.
// RULE12 - warning interrupt enable raises a request while the flag is set.
// RULE13 - detect reset enable with detect enabled makes detection reset the part.
// RULE14 - stop enable keeps the detector running in stop mode when set.
// RULE15 - detect enable turns detection on and qualifies reset and stop enables.
// RULE16 - bandgap buffer enable turns the reference buffer on.
// RULE17 - software should write power control early to lock it.
// RULE18 - bus-clock window opens after 6144, 49152 or 196608 cycles.
// RULE19 - unused bits read zero and ignore writes.
`timescale 1ns/1ns
module sol_regs
    import sol_pkg::*;
#(
    parameter logic [11:0] PART_NUMBER    = 12'h5a3, // arbitrary value
    parameter logic [3:0]  SILICON_REV    = 4'h1,    // arbitrary value
    parameter int          WIN_OPEN_SHORT = WIN_BUS_SHORT,
    parameter int          WIN_OPEN_MID   = WIN_BUS_MID,
    parameter int          WIN_OPEN_LONG  = WIN_BUS_LONG
)(
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    input  wire logic              i_ce,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [DATA_W-1:0]      o_rdata,
    input  wire logic [1:0]        i_wd_timeout_sel,
    input  wire logic              i_lpo_tick,
    input  wire logic              i_rst_status_wr,
    input  wire logic [DATA_W-1:0] i_rst_status_data,
    input  wire logic              i_conv_hw_trigger_enable,
    input  wire logic              i_rtc_overflow,
    input  wire logic              i_irq_pin,
    input  wire logic              i_low_volt_warning,
    input  wire logic              i_low_volt_detect,
    input  wire logic              i_stop_mode,
    output logic                   o_wd_clock_select,
    output logic                   o_wd_window_enable,
    output logic                   o_wd_serviced,
    output logic                   o_wd_window_reset,
    output logic                   o_conv_trigger,
    output logic                   o_clock_out_pin,
    output logic                   o_clock_out_pin_en,
    output logic                   o_lvw_irq_req,
    output logic                   o_lvd_active,
    output logic                   o_lvd_reset,
    output logic                   o_bandgap_buffer_enable,
    output logic                   o_irq
);

    typedef struct packed {
        logic                 wd_clk_sel;
        logic                 wd_win_en;
        logic                 conv_trig_sel;
        logic [CLK_DIV_W-1:0] clk_div;
        logic                 opt2_locked;
        logic                 lvw_flag;
        logic                 lvw_ie;
        logic                 lvd_re;
        logic                 lvd_se;
        logic                 lvd_en;
        logic                 bg_buf_en;
        logic                 pwr1_locked;
        logic [IRQ_W-1:0]     irq_status;
        logic [IRQ_W-1:0]     irq_mask;
        logic [WD_CNT_W-1:0]  wd_count;
        sol_svc_e             svc;
        logic                 wd_serviced;
        logic                 win_reset;
        logic                 lvd_reset;
        logic                 lvd_seen;
        logic                 conv_trig;
        logic [DATA_W-1:0]    rdata;
    } sol_state_s;

    sol_state_s st_ff;
    sol_state_s nxt_st;

    logic [IRQ_W-1:0] events;
    logic             lvd_running;
    logic             wr_opt2;
    logic             wr_pwr1;

    // count at which the service window opens for the active source
    function automatic logic [WD_CNT_W-1:0] win_open(input logic bus_clk, input logic [1:0] sel);
        logic [WD_CNT_W-1:0] cnt;
        cnt = '0;
        if (bus_clk) begin
            if (sel == WD_SHORT) begin
                cnt = WD_CNT_W'(WIN_OPEN_SHORT); // [RULE18]
            end else if (sel == WD_MID) begin
                cnt = WD_CNT_W'(WIN_OPEN_MID); // [RULE18]
            end else begin
                cnt = WD_CNT_W'(WIN_OPEN_LONG); // [RULE18]
            end
        end else begin
            if (sel == WD_SHORT) begin
                cnt = WD_CNT_W'(WIN_LPO_SHORT);
            end else if (sel == WD_MID) begin
                cnt = WD_CNT_W'(WIN_LPO_MID);
            end else begin
                cnt = WD_CNT_W'(WIN_LPO_LONG);
            end
        end
        return cnt;
    endfunction

    // register read view, unused positions are zero
    function automatic logic [DATA_W-1:0] read_view(input sol_state_s s, input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] d;
        d = '0; // [RULE19]
        if (a == OFS_SYS_OPT2) begin
            d[BIT_WD_CLK_SEL] = s.wd_clk_sel;
            d[BIT_WD_WIN_EN] = s.wd_win_en;
            d[BIT_CONV_TRIG] = s.conv_trig_sel;
            d[POS_CLK_DIV +: CLK_DIV_W] = s.clk_div;
        end else if (a == OFS_PART_ID_HI) begin
            d[POS_REVISION +: 4] = SILICON_REV; // [RULE9]
            d[POS_PART_HI +: 4] = PART_NUMBER[11:8]; // [RULE8]
        end else if (a == OFS_PART_ID_LO) begin
            d = PART_NUMBER[7:0]; // [RULE8]
        end else if (a == OFS_PWR_CTRL1) begin
            d[BIT_LVW_FLAG] = s.lvw_flag;
            d[BIT_LVW_IE] = s.lvw_ie;
            d[BIT_LVD_RE] = s.lvd_re;
            d[BIT_LVD_SE] = s.lvd_se;
            d[BIT_LVD_EN] = s.lvd_en;
            d[BIT_BG_BUF_EN] = s.bg_buf_en;
        end else if (a == OFS_IRQ_STATUS) begin
            d[IRQ_W-1:0] = s.irq_status;
        end else if (a == OFS_IRQ_MASK) begin
            d[IRQ_W-1:0] = s.irq_mask;
        end
        return d;
    endfunction

    assign wr_opt2 = i_wr && (i_addr == OFS_SYS_OPT2);
    assign wr_pwr1 = i_wr && (i_addr == OFS_PWR_CTRL1);

    // detector runs when enabled, and in stop mode only with stop enable
    assign lvd_running = st_ff.lvd_en && (!i_stop_mode || st_ff.lvd_se); // [RULE14] [RULE15]

    always_comb begin
        nxt_st             = st_ff;
        events             = '0;
        nxt_st.wd_serviced = 1'b0;
        nxt_st.win_reset   = 1'b0;

        // system_options_two: locked bits keep their first written value
        if (wr_opt2) begin
            if (!st_ff.opt2_locked) begin
                nxt_st.wd_clk_sel  = i_wdata[BIT_WD_CLK_SEL]; // [RULE1] [RULE4]
                nxt_st.wd_win_en   = i_wdata[BIT_WD_WIN_EN]; // [RULE4]
                nxt_st.opt2_locked = 1'b1; // [RULE4]
            end
            nxt_st.conv_trig_sel = i_wdata[BIT_CONV_TRIG];
            nxt_st.clk_div       = i_wdata[POS_CLK_DIV +: CLK_DIV_W];
        end

        // power_mgmt_status_control_one
        if (wr_pwr1) begin
            if (!st_ff.pwr1_locked) begin
                nxt_st.lvd_re      = i_wdata[BIT_LVD_RE]; // [RULE4] [RULE13]
                nxt_st.lvd_en      = i_wdata[BIT_LVD_EN]; // [RULE4] [RULE15]
                nxt_st.pwr1_locked = 1'b1; // [RULE4] [RULE17]
            end
            nxt_st.lvw_ie    = i_wdata[BIT_LVW_IE];
            nxt_st.lvd_se    = i_wdata[BIT_LVD_SE]; // [RULE14]
            nxt_st.bg_buf_en = i_wdata[BIT_BG_BUF_EN]; // [RULE16]
        end

        // warning flag: presence sets it, acknowledge clears only when gone
        if (i_low_volt_warning) begin
            nxt_st.lvw_flag = 1'b1; // [RULE10]
            events[EV_LVW_SET] = !st_ff.lvw_flag;
        end else if (wr_pwr1 && i_wdata[BIT_LVW_ACK]) begin
            nxt_st.lvw_flag = 1'b0; // [RULE11]
        end

        // detect reset request, held while the event lasts
        nxt_st.lvd_reset = lvd_running && st_ff.lvd_re && i_low_volt_detect; // [RULE13]
        nxt_st.lvd_seen  = lvd_running && i_low_volt_detect;
        events[EV_LVD_TRIP] = nxt_st.lvd_seen && !st_ff.lvd_seen;

        // watchdog period counter, restarted by a completed service
        if (i_wd_timeout_sel != WD_OFF && (st_ff.wd_clk_sel || i_lpo_tick)) begin
            if (st_ff.wd_count != '1) begin
                nxt_st.wd_count = st_ff.wd_count + 18'h1; // [RULE1]
            end
        end

        if (i_rst_status_wr && i_wd_timeout_sel != WD_OFF) begin
            if (st_ff.wd_win_en &&
                st_ff.wd_count < win_open(st_ff.wd_clk_sel, i_wd_timeout_sel)) begin
                // early write in window mode forces a reset
                nxt_st.win_reset      = 1'b1; // [RULE3]
                nxt_st.svc            = SVC_IDLE;
                events[EV_WIN_VIOL]   = 1'b1;
            end else begin
                case (st_ff.svc)
                    SVC_IDLE: begin
                        if (i_rst_status_data == SVC_FIRST) begin
                            nxt_st.svc = SVC_ARMED; // [RULE2]
                        end
                    end
                    SVC_ARMED: begin
                        if (i_rst_status_data == SVC_SECOND) begin
                            nxt_st.wd_count        = '0; // [RULE2]
                            nxt_st.wd_serviced     = 1'b1;
                            events[EV_WD_SERVICED] = 1'b1;
                            nxt_st.svc             = SVC_IDLE;
                        end else if (i_rst_status_data != SVC_FIRST) begin
                            nxt_st.svc = SVC_IDLE;
                        end
                    end
                    default: begin
                        nxt_st.svc = SVC_IDLE;
                    end
                endcase
            end
        end

        // converter hardware trigger source
        if (i_conv_hw_trigger_enable) begin
            nxt_st.conv_trig = st_ff.conv_trig_sel ? i_irq_pin : i_rtc_overflow; // [RULE5]
        end else begin
            nxt_st.conv_trig = 1'b0;
        end

        // interrupt status: read clears, a same-cycle event wins
        if (i_wr && i_addr == OFS_IRQ_MASK) begin
            nxt_st.irq_mask = i_wdata[IRQ_W-1:0];
        end
        if (i_rd && i_addr == OFS_IRQ_STATUS) begin
            nxt_st.irq_status = events;
        end else begin
            nxt_st.irq_status = st_ff.irq_status | events;
        end

        // read data stands only in the cycle after the strobe
        nxt_st.rdata = i_rd ? read_view(st_ff, i_addr) : '0; // [RULE8] [RULE19]
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            st_ff.wd_clk_sel    <= RST_WD_CLK_SEL;
            st_ff.wd_win_en     <= RST_WD_WIN_EN;
            st_ff.conv_trig_sel <= RST_CONV_TRIG;
            st_ff.clk_div       <= RST_CLK_DIV;
            st_ff.opt2_locked   <= 1'b0;
            st_ff.lvw_flag      <= 1'b0;
            st_ff.lvw_ie        <= RST_LVW_IE;
            st_ff.lvd_re        <= RST_LVD_RE;
            st_ff.lvd_se        <= RST_LVD_SE;
            st_ff.lvd_en        <= RST_LVD_EN;
            st_ff.bg_buf_en     <= RST_BG_BUF_EN;
            st_ff.pwr1_locked   <= 1'b0;
            st_ff.irq_status    <= '0;
            st_ff.irq_mask      <= RST_IRQ_MASK;
            st_ff.wd_count      <= '0;
            st_ff.svc           <= SVC_IDLE;
            st_ff.wd_serviced   <= 1'b0;
            st_ff.win_reset     <= 1'b0;
            st_ff.lvd_reset     <= 1'b0;
            st_ff.lvd_seen      <= 1'b0;
            st_ff.conv_trig     <= 1'b0;
            st_ff.rdata         <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    sol_clkdiv u_clkdiv (
        .i_clock      (i_clock),
        .i_nrst       (i_nrst),
        .i_ce         (i_ce),
        .i_div        (st_ff.clk_div),
        .o_clk_out    (o_clock_out_pin),
        .o_clk_out_en (o_clock_out_pin_en)
    );

    assign o_rdata                 = st_ff.rdata;
    assign o_wd_clock_select       = st_ff.wd_clk_sel; // [RULE1]
    assign o_wd_window_enable      = st_ff.wd_win_en;
    assign o_wd_serviced           = st_ff.wd_serviced;
    assign o_wd_window_reset       = st_ff.win_reset;
    assign o_conv_trigger          = st_ff.conv_trig;
    assign o_lvw_irq_req           = st_ff.lvw_ie && st_ff.lvw_flag; // [RULE12]
    assign o_lvd_active            = lvd_running;
    assign o_lvd_reset             = st_ff.lvd_reset;
    assign o_bandgap_buffer_enable = st_ff.bg_buf_en; // [RULE16]
    assign o_irq                   = |(st_ff.irq_status & st_ff.irq_mask);

endmodule

// file: hw/sol_pkg.sv
/*
 * constants of the system option and low-voltage register bank:
 * register indices, field positions, reset values and watchdog window counts.
 * assumes an 8-bit register port with a 3-bit register index.
 */
package sol_pkg;

    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 8;

    // register indices on the register port
    localparam logic [2:0]  OFS_SYS_OPT2    = 3'h0;
    localparam logic [2:0]  OFS_PART_ID_HI  = 3'h1;
    localparam logic [2:0]  OFS_PART_ID_LO  = 3'h2;
    localparam logic [2:0]  OFS_PWR_CTRL1   = 3'h3;
    localparam logic [2:0]  OFS_IRQ_STATUS  = 3'h4;
    localparam logic [2:0]  OFS_IRQ_MASK    = 3'h5;

    // system_options_two fields
    localparam int          BIT_WD_CLK_SEL  = 7;
    localparam int          BIT_WD_WIN_EN   = 6;
    localparam int          BIT_CONV_TRIG   = 4;
    localparam int          POS_CLK_DIV     = 0;
    localparam int          CLK_DIV_W       = 3;

    // power_mgmt_status_control_one fields
    localparam int          BIT_LVW_FLAG    = 7;
    localparam int          BIT_LVW_ACK     = 6;
    localparam int          BIT_LVW_IE      = 5;
    localparam int          BIT_LVD_RE      = 4;
    localparam int          BIT_LVD_SE      = 3;
    localparam int          BIT_LVD_EN      = 2;
    localparam int          BIT_BG_BUF_EN   = 0;

    // part_id_high layout
    localparam int          POS_REVISION    = 4;
    localparam int          POS_PART_HI     = 0;

    // interrupt status and mask layout
    localparam int          IRQ_W           = 4;
    localparam int          EV_LVW_SET      = 0;
    localparam int          EV_WIN_VIOL     = 1;
    localparam int          EV_WD_SERVICED  = 2;
    localparam int          EV_LVD_TRIP     = 3;

    // reset values
    localparam logic        RST_WD_CLK_SEL  = 1'b0;
    localparam logic        RST_WD_WIN_EN   = 1'b0;
    localparam logic        RST_CONV_TRIG   = 1'b0;
    localparam logic [2:0]  RST_CLK_DIV     = 3'h0;
    localparam logic        RST_LVW_IE      = 1'b0;
    localparam logic        RST_LVD_RE      = 1'b1;
    localparam logic        RST_LVD_SE      = 1'b1;
    localparam logic        RST_LVD_EN      = 1'b1;
    localparam logic        RST_BG_BUF_EN   = 1'b0;
    localparam logic [3:0]  RST_IRQ_MASK    = 4'h0;

    // watchdog service sequence bytes
    localparam logic [7:0]  SVC_FIRST       = 8'h55;
    localparam logic [7:0]  SVC_SECOND      = 8'haa;

    // watchdog timeout select codes
    localparam logic [1:0]  WD_OFF          = 2'h0;
    localparam logic [1:0]  WD_SHORT        = 2'h1;
    localparam logic [1:0]  WD_MID          = 2'h2;

    // window-open counts, first three quarters of each period
    localparam int          WIN_BUS_SHORT   = 6144;
    localparam int          WIN_BUS_MID     = 49152;
    localparam int          WIN_BUS_LONG    = 196608;
    localparam int          WIN_LPO_SHORT   = 24;
    localparam int          WIN_LPO_MID     = 192;
    localparam int          WIN_LPO_LONG    = 768;
    localparam int          WD_CNT_W        = 18;

    typedef enum logic {
        SVC_IDLE  = 1'b0,
        SVC_ARMED = 1'b1
    } sol_svc_e;

endpackage

// file: hw/sol_clkdiv.sv
/*
 * divided bus-clock output: toggles every div cycles, so the output
 * period is twice div bus cycles; zero div disables the output.
 * assumes div is a register value stable for many cycles.
 */
`timescale 1ns/1ns
module sol_clkdiv
    import sol_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_nrst,
    input  wire logic                 i_ce,
    input  wire logic [CLK_DIV_W-1:0] i_div,
    output logic                      o_clk_out,
    output logic                      o_clk_out_en
);

    typedef struct packed {
        logic [CLK_DIV_W-1:0] cnt;
        logic [CLK_DIV_W-1:0] div_seen;
        logic                 level;
        logic                 en;
    } sol_div_s;

    sol_div_s st_ff;
    sol_div_s nxt_st;

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.div_seen = i_div;
        nxt_st.en       = (i_div != '0); // [RULE6] [RULE7]
        if (i_div == '0 || i_div != st_ff.div_seen) begin
            // restart cleanly whenever the ratio changes
            nxt_st.cnt   = '0;
            nxt_st.level = 1'b0; // [RULE7]
        end else if (st_ff.cnt == i_div - 3'h1) begin
            nxt_st.cnt   = '0;
            nxt_st.level = ~st_ff.level; // [RULE6]
        end else begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_clk_out    = st_ff.level;
    assign o_clk_out_en = st_ff.en;

endmodule

// file: tb/sol_regs_asserts.sv
/* port-level assertions for the sol_regs register bank.
   bound into every sol_regs instance; sees its ports only. */
`timescale 1ns/1ns
module sol_regs_asserts
    import sol_pkg::*;
#(
    parameter logic [11:0] PART_NUMBER = 12'h5a3,
    parameter logic [3:0]  SILICON_REV = 4'h1
)(
    input wire logic              i_clock,
    input wire logic              i_nrst,
    input wire logic              i_ce,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              i_rst_status_wr,
    input wire logic [DATA_W-1:0] i_rst_status_data,
    input wire logic              i_rtc_overflow,
    input wire logic              i_irq_pin,
    input wire logic              i_low_volt_warning,
    input wire logic              i_low_volt_detect,
    input wire logic              o_wd_window_enable,
    input wire logic              o_wd_serviced,
    input wire logic              o_wd_window_reset,
    input wire logic              o_conv_trigger,
    input wire logic              o_clock_out_pin,
    input wire logic              o_clock_out_pin_en,
    input wire logic              o_lvd_reset
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    rd_idle_a: assert property ($past(!i_rd && i_ce) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    id_high_a: assert property ($past(i_rd && i_ce && i_nrst && i_addr == OFS_PART_ID_HI)
        |-> o_rdata == {SILICON_REV, PART_NUMBER[11:8]}) else $error("high id read wrong");
    id_low_a: assert property ($past(i_rd && i_ce && i_nrst && i_addr == OFS_PART_ID_LO)
        |-> o_rdata == PART_NUMBER[7:0]) else $error("low id read wrong");
    unmapped_zero_a: assert property ($past(i_rd && i_ce && i_nrst && i_addr[2:1] == 2'b11)
        |-> o_rdata == 8'h00) else $error("unmapped read not zero");
    warn_flag_a: assert property ($past(i_rd && i_ce && i_nrst && i_addr == OFS_PWR_CTRL1)
        && $past(i_low_volt_warning && i_ce && i_nrst, 2) |-> o_rdata[BIT_LVW_FLAG]) else $error("warning flag not set");
    early_reset_a: assert property (o_wd_window_reset |-> $past(i_rst_status_wr) && o_wd_window_enable)
        else $error("window reset without early write");
    service_cause_a: assert property (o_wd_serviced |-> $past(i_rst_status_wr && i_rst_status_data == SVC_SECOND))
        else $error("service without second byte");
    trig_quiet_a: assert property ($past(i_ce && i_nrst && !i_rtc_overflow && !i_irq_pin) |-> !o_conv_trigger)
        else $error("trigger without source");
    clk_out_off_a: assert property (o_clock_out_pin |-> o_clock_out_pin_en)
        else $error("clock out active while disabled");
    lvd_cause_a: assert property (o_lvd_reset && $past(i_ce) |-> $past(i_low_volt_detect))
        else $error("detect reset without event");
endmodule

bind sol_regs sol_regs_asserts #(.PART_NUMBER(PART_NUMBER), .SILICON_REV(SILICON_REV)) u_chk (
    .i_clock, .i_nrst, .i_ce, .i_addr, .i_rd, .o_rdata, .i_rst_status_wr, .i_rst_status_data, .i_rtc_overflow,
    .i_irq_pin, .i_low_volt_warning, .i_low_volt_detect, .o_wd_window_enable, .o_wd_serviced, .o_wd_window_reset,
    .o_conv_trigger, .o_clock_out_pin, .o_clock_out_pin_en, .o_lvd_reset);

// file: tb/testbench.sv
/* self-checking bench for sol_regs with a register model.
   assumes short watchdog windows of 12/24/48 bus cycles. */
`timescale 1ns/1ns
module testbench;
    import sol_pkg::*;
    localparam logic [11:0] PN  = 12'h3c7; // arbitrary value
    localparam logic [3:0]  REV = 4'h2;    // arbitrary value
    logic       i_clock = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_rst_status_wr = 1'b0;
    logic       i_rtc_overflow = 1'b0, i_irq_pin = 1'b0, i_low_volt_warning = 1'b0, i_low_volt_detect = 1'b0;
    logic       i_ce = 1'b1, i_stop_mode = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [1:0] i_wd_timeout_sel = 2'h0;
    logic [7:0] i_wdata = 8'h00, i_rst_status_data = 8'h00, o_rdata, pwr_m = 8'h1c, opt_m = 8'h00, mk_m = 8'h00;
    logic       o_wcs, o_wwe, o_svc, o_wrst, o_trg, o_cko, o_cken, o_lvwi, o_lva, o_lvr, o_bg, o_irq, p;
    logic [3:0] st_m = 4'h0;
    logic [31:0] seed = 32'hc76e65ac, r;
    bit         lk_o = 0, lk_p = 0, fl_m = 0;
    int         errors = 0, samples_checked = 0, n;

    always #25 i_clock = ~i_clock;

    sol_regs #(.PART_NUMBER(PN), .SILICON_REV(REV), .WIN_OPEN_SHORT(12), .WIN_OPEN_MID(24), .WIN_OPEN_LONG(48)) u_dut (
        .i_clock, .i_nrst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_wd_timeout_sel, .i_lpo_tick(1'b0),
        .i_rst_status_wr, .i_rst_status_data, .i_conv_hw_trigger_enable(1'b1), .i_rtc_overflow, .i_irq_pin,
        .i_low_volt_warning, .i_low_volt_detect, .i_stop_mode, .o_wd_clock_select(o_wcs), .o_wd_window_enable(o_wwe),
        .o_wd_serviced(o_svc), .o_wd_window_reset(o_wrst), .o_conv_trigger(o_trg), .o_clock_out_pin(o_cko),
        .o_clock_out_pin_en(o_cken), .o_lvw_irq_req(o_lvwi), .o_lvd_active(o_lva), .o_lvd_reset(o_lvr),
        .o_bandgap_buffer_enable(o_bg), .o_irq(o_irq));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock); i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clock); i_wr <= 1'b0;
        if (a == OFS_SYS_OPT2) begin
            opt_m = {lk_o ? opt_m[7:6] : d[7:6], 1'b0, d[4], 1'b0, d[2:0]};
            lk_o = 1;
        end
        if (a == OFS_PWR_CTRL1) begin
            pwr_m = {2'b00, d[5], lk_p ? pwr_m[4] : d[4], d[3], lk_p ? pwr_m[2] : d[2], 1'b0, d[0]};
            lk_p = 1;
        end
        if (a == OFS_IRQ_MASK) mk_m = {4'h0, d[3:0]};
    endtask
    task automatic rd(input logic [2:0] a);
        logic [7:0] e;
        e = (a == 0) ? opt_m : (a == 1) ? {REV, PN[11:8]} : (a == 2) ? PN[7:0] : (a == 3) ? pwr_m | {fl_m, 7'h00}
          : (a == 4) ? {4'h0, st_m} : (a == 5) ? mk_m : 8'h00;
        @(posedge i_clock); i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock); i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, e);
        if (a == OFS_IRQ_STATUS) st_m = 4'h0;
    endtask
    task automatic sw(input logic [7:0] d, input logic er, input logic es);
        @(posedge i_clock); i_rst_status_wr <= 1'b1; i_rst_status_data <= d;
        @(posedge i_clock); i_rst_status_wr <= 1'b0;
        #1 chk("window_reset", {7'h0, o_wrst}, {7'h0, er});
        chk("serviced", {7'h0, o_svc}, {7'h0, es});
        st_m[1] |= er;
        st_m[2] |= es;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clock);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge i_clock);
        i_nrst <= 1'b1;
        for (int a = 0; a < 8; a++) rd(a[2:0]);
        i_ce <= 1'b0;
        wr(OFS_IRQ_MASK, 8'hff);
        mk_m = 8'h00;
        i_ce <= 1'b1;
        rd(OFS_IRQ_MASK);
        i_low_volt_detect <= 1'b1;
        repeat (3) @(posedge i_clock);
        #1 chk("lvd_reset", {7'h0, o_lvr}, 8'h01);
        i_low_volt_detect <= 1'b0;
        st_m[3] = 1;
        for (int a = 0; a < 3; a++) begin
            r = xs();
            wr(a[2:0], (a == 0) ? {2'b11, r[5:0]} : r[7:0]);
            r = xs();
            wr(a[2:0], r[7:0]);
            rd(a[2:0]);
        end
        chk("wd_clock_select", {7'h0, o_wcs}, 8'h01);
        r = xs();
        wr(OFS_PWR_CTRL1, {r[7:6], 3'b100, r[2], 1'b1, r[0]});
        r = xs();
        wr(OFS_PWR_CTRL1, {r[7], 2'b01, r[4:0]});
        rd(OFS_PWR_CTRL1);
        chk("bandgap", {7'h0, o_bg}, {7'h0, pwr_m[0]});
        chk("lvd_active", {7'h0, o_lva}, {7'h0, pwr_m[2]});
        i_stop_mode <= 1'b1;
        @(posedge i_clock);
        #1 chk("lvd_stop", {7'h0, o_lva}, {7'h0, pwr_m[2] & pwr_m[3]});
        i_stop_mode <= 1'b0;
        i_low_volt_detect <= 1'b1;
        repeat (3) @(posedge i_clock);
        #1 chk("lvd_reset", {7'h0, o_lvr}, 8'h00);
        i_low_volt_detect <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (!k[0]) wr(OFS_SYS_OPT2, {3'b000, k[1], 4'h0});
            i_rtc_overflow <= k[0];
            i_irq_pin <= ~k[0];
            repeat (2) @(posedge i_clock);
            #1 chk("conv_trigger", {7'h0, o_trg}, {7'h0, k[0] ^ k[1]});
        end
        for (int d = 1; d < 8; d++) begin
            wr(OFS_SYS_OPT2, d[7:0]);
            repeat (3) @(posedge i_clock);
            #1 chk("clk_out_en", {7'h0, o_cken}, 8'h01);
            for (int k = 0; k < 2; k++) begin
                n = 0;
                p = o_cko;
                while (o_cko === p && n < 20) begin
                    @(posedge i_clock);
                    #1 n++;
                end
            end
            chk("clk_out_half", n[7:0], d[7:0]);
        end
        wr(OFS_SYS_OPT2, 8'h00);
        repeat (3) @(posedge i_clock);
        #1 chk("clk_out_off", {6'h0, o_cken, o_cko}, 8'h00);
        for (int s = 1; s < 4; s++) begin
            i_wd_timeout_sel <= s[1:0];
            repeat (60) @(posedge i_clock);
            sw(SVC_FIRST, 1'b0, 1'b0);
            sw(SVC_SECOND, 1'b0, 1'b1);
            repeat ((12 << (s - 1)) - 4) @(posedge i_clock);
            sw(SVC_FIRST, 1'b1, 1'b0);
        end
        wr(OFS_IRQ_MASK, 8'h01);
        i_low_volt_warning <= 1'b1;
        repeat (3) @(posedge i_clock);
        fl_m = 1;
        st_m[0] = 1;
        #1 chk("irq", {6'h0, o_lvwi, o_irq}, 8'h03);
        wr(OFS_PWR_CTRL1, pwr_m | 8'h40);
        rd(OFS_PWR_CTRL1);
        i_low_volt_warning <= 1'b0;
        wr(OFS_PWR_CTRL1, pwr_m | 8'h40);
        fl_m = 0;
        rd(OFS_PWR_CTRL1);
        chk("lvw_irq", {7'h0, o_lvwi}, 8'h00);
        rd(OFS_IRQ_STATUS);
        rd(OFS_IRQ_STATUS);
        chk("irq_clear", {7'h0, o_irq}, 8'h00);
        wrap_up();
    end
endmodule
